// >>> pei_pkg.sv
// Purpose: Shared constants and carrier types for the port edge detect block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Six port pins, registers eight bits wide in the low byte
package pei_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int PEI_PINS = 6;
  localparam int PEI_REG_W = 8;
  localparam int PEI_ADDR_W = 8;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] PEI_OFS_THRESH = 8'h00;
  localparam logic [7:0] PEI_OFS_RISE = 8'h04;
  localparam logic [7:0] PEI_OFS_FALL = 8'h08;
  localparam logic [7:0] PEI_OFS_FLAGS = 8'h0C;
  localparam logic [7:0] PEI_OFS_CTRL = 8'h10;
  localparam logic [7:0] PEI_OFS_PINS = 8'h14;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int PEI_CTRL_MASTER_BIT = 0;
  localparam int PEI_CTRL_SUMMARY_BIT = 1;
  localparam logic [5:0] PEI_PIN_RESET = 6'h00;
  localparam logic [31:0] PEI_RDATA_ZERO = 32'h0000_0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [PEI_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } pei_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pei_apb_rsp_t;

  typedef enum logic [0:0] {
    PEI_IDLE,
    PEI_ACCESS
  } pei_bus_state_t;

endpackage : pei_pkg

// >>> pei_pin_sync.sv
// Purpose: Two-stage synchroniser plus previous-sample edge detection per pin
// Assumes: Pin already passed through the selected input buffer
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
module pei_pin_sync (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic pinIn,
  output logic pinLevel,
  output logic rise,
  output logic fall
);

  typedef struct packed {
    logic meta;
    logic level;
    logic prev;
  } pei_sync_state_t;

  pei_sync_state_t state;
  pei_sync_state_t next_state;

  always_comb begin
    next_state.meta = pinIn;
    next_state.level = state.meta;
    next_state.prev = state.level;
    if (!nrst) begin
      next_state = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    state <= next_state;
  end

  assign pinLevel = state.level;
  assign rise = state.level & ~state.prev;
  assign fall = ~state.level & state.prev;

endmodule : pei_pin_sync

// >>> pei_buf_select.sv
// Purpose: Picks Schmitt or TTL buffer output per pin
// Assumes: Both analog buffer outputs arrive as digital levels
// Notes: Pure combinational mux
`timescale 1ns/100ps
module pei_buf_select (
  input wire logic [5:0] schmittIn,
  input wire logic [5:0] ttlIn,
  input wire logic [5:0] thresholdSel,
  output logic [5:0] selected
);

  assign selected = (thresholdSel & schmittIn) | (~thresholdSel & ttlIn);

endmodule : pei_buf_select

// >>> pei_port_edge.sv
// Purpose: Per-pin rising/falling edge detection with flags and wake request
// Assumes: Pin inputs synchronous to sys_clk domain after internal sync
// Notes: Registers reached over APB, zero wait state
//
// Function
// - Threshold bit one selects Schmitt buffer, zero selects TTL buffer.
// - Threshold bits zero to five map to pins zero to five.
// - Bits seven and six of the four registers read zero, ignore writes.
// - Each pin has separate rising and falling detectors with own enables.
// - Both enables set flag edges of either polarity.
// - Flag sets on enabled rising edge or enabled falling edge.
// - Pin with both enables clear never sets its flag.
// - Detection and flags continue with master enable clear; only interrupt and wake requests suppressed.
// - Interrupt request raised when a flag is set and master enable is one.
// - Summary flag is OR of all pin flags.
// - Software clears flags with zeros; a simultaneous enabled edge wins.
// - Enabled edge wakes device from sleep when master enable set.
// - Edge during sleep updates flags before first instruction after wake.
// - All four registers reset to zero on every reset.
`timescale 1ns/100ps
module pei_port_edge (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] portPinSchmitt,
  input wire logic [5:0] portPinTtl,
  output logic [5:0] portPinLevel,
  output logic changeIrqRequest,
  output logic wakeRequest,
  output logic changeIrqSummaryFlag
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [5:0] inputThresholdSelect;
    logic [5:0] risingEdgeEnable;
    logic [5:0] fallingEdgeEnable;
    logic [5:0] pinChangeFlags;
    logic changeIrqMasterEnable;
    logic [31:0] rdata;
    logic slvErr;
  } pei_state_t;

  pei_state_t state;
  pei_state_t next_state;

  logic [5:0] selectedPins;
  logic [5:0] riseEdge;
  logic [5:0] fallEdge;
  logic [5:0] enabledEdge;
  logic setupPhase;
  logic wrLow;
  logic knownAddr;

  // ****************************************
  // Input buffer selection and edge detect
  // ****************************************
  pei_buf_select u_buf_select (
    .schmittIn(portPinSchmitt),
    .ttlIn(portPinTtl),
    .thresholdSel(state.inputThresholdSelect),
    .selected(selectedPins)
  );

  genvar gi;
  generate
    for (gi = 0; gi < pei_pkg::PEI_PINS; gi++) begin : g_pin
      pei_pin_sync u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pinIn(selectedPins[gi]),
        .pinLevel(portPinLevel[gi]),
        .rise(riseEdge[gi]),
        .fall(fallEdge[gi])
      );
    end
  endgenerate

  // Independent detectors; both enables give either polarity
  assign enabledEdge = (riseEdge & state.risingEdgeEnable) | (fallEdge & state.fallingEdgeEnable);

  // ****************************************
  // Bus decode
  // ****************************************
  // Read data is captured in setup so the access phase ends at once
  assign setupPhase = psel & ~penable;
  assign wrLow = psel & penable & pwrite & pstrb[0];
  always_comb begin
    case (paddr)
      pei_pkg::PEI_OFS_THRESH,
      pei_pkg::PEI_OFS_RISE,
      pei_pkg::PEI_OFS_FALL,
      pei_pkg::PEI_OFS_FLAGS,
      pei_pkg::PEI_OFS_CTRL,
      pei_pkg::PEI_OFS_PINS: knownAddr = 1'b1;
      default: knownAddr = 1'b0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_state = state;
    next_state.slvErr = 1'b0;
    if (setupPhase) begin
      next_state.slvErr = ~knownAddr;
      next_state.rdata = pei_pkg::PEI_RDATA_ZERO;
      case (paddr)
        pei_pkg::PEI_OFS_THRESH: next_state.rdata[5:0] = state.inputThresholdSelect;
        pei_pkg::PEI_OFS_RISE: next_state.rdata[5:0] = state.risingEdgeEnable;
        pei_pkg::PEI_OFS_FALL: next_state.rdata[5:0] = state.fallingEdgeEnable;
        pei_pkg::PEI_OFS_FLAGS: next_state.rdata[5:0] = state.pinChangeFlags;
        pei_pkg::PEI_OFS_CTRL: begin
          next_state.rdata[pei_pkg::PEI_CTRL_MASTER_BIT] = state.changeIrqMasterEnable;
          next_state.rdata[pei_pkg::PEI_CTRL_SUMMARY_BIT] = |state.pinChangeFlags;
        end
        pei_pkg::PEI_OFS_PINS: next_state.rdata[5:0] = portPinLevel;
        default: next_state.rdata = pei_pkg::PEI_RDATA_ZERO;
      endcase
    end
    if (wrLow) begin
      // Upper bits dropped, so unimplemented bits stay zero
      case (paddr)
        pei_pkg::PEI_OFS_THRESH: next_state.inputThresholdSelect = pwdata[5:0];
        pei_pkg::PEI_OFS_RISE: next_state.risingEdgeEnable = pwdata[5:0];
        pei_pkg::PEI_OFS_FALL: next_state.fallingEdgeEnable = pwdata[5:0];
        pei_pkg::PEI_OFS_FLAGS: next_state.pinChangeFlags = pwdata[5:0];
        pei_pkg::PEI_OFS_CTRL: next_state.changeIrqMasterEnable = pwdata[pei_pkg::PEI_CTRL_MASTER_BIT];
        default: next_state.slvErr = 1'b0;
      endcase
    end
    // Hardware set wins over a clearing write; runs regardless of master enable
    next_state.pinChangeFlags = next_state.pinChangeFlags | enabledEdge;
    if (!nrst) begin
      next_state.inputThresholdSelect = pei_pkg::PEI_PIN_RESET;
      next_state.risingEdgeEnable = pei_pkg::PEI_PIN_RESET;
      next_state.fallingEdgeEnable = pei_pkg::PEI_PIN_RESET;
      next_state.pinChangeFlags = pei_pkg::PEI_PIN_RESET;
      next_state.changeIrqMasterEnable = 1'b0;
      next_state.rdata = pei_pkg::PEI_RDATA_ZERO;
      next_state.slvErr = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    state <= next_state;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pready = 1'b1;
  assign prdata = state.rdata;
  assign pslverr = state.slvErr & psel & penable;
  assign changeIrqSummaryFlag = |state.pinChangeFlags;
  // Level request: held while any flag stands and master enable is on
  assign changeIrqRequest = changeIrqSummaryFlag & state.changeIrqMasterEnable;
  // Wake uses the same level; flags are already set when the core resumes
  assign wakeRequest = changeIrqSummaryFlag & state.changeIrqMasterEnable;

endmodule : pei_port_edge

// >>> pei_port_edge_asserts.sv
// Purpose: Port-level rule checker for pei_port_edge
// Assumes: One clock, synchronous active-low reset
// Notes: Attached by the bind at the foot
`timescale 1ns/100ps
module pei_port_edge_asserts (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [5:0] portPinSchmitt,
  input wire logic [5:0] portPinTtl,
  input wire logic [5:0] portPinLevel,
  input wire logic changeIrqRequest,
  input wire logic wakeRequest,
  input wire logic changeIrqSummaryFlag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire logic acc = psel && penable;
  property p_wake; wakeRequest == changeIrqRequest; endproperty
  a_wake: assert property (p_wake) else $error("wake differs from request");
  property p_irq; changeIrqRequest |-> changeIrqSummaryFlag; endproperty
  a_irq: assert property (p_irq) else $error("request without flag");
  property p_cause; $rose(changeIrqSummaryFlag) |-> $past(portPinLevel) != $past(portPinLevel, 2); endproperty
  a_cause: assert property (p_cause) else $error("flag without pin change");
  // Sync chain is cleared by reset, so wait two edges after release
  property p_level; $past(nrst, 2) && $past(portPinSchmitt, 2) == $past(portPinTtl, 2)
    |-> portPinLevel == $past(portPinSchmitt, 2); endproperty
  a_level: assert property (p_level) else $error("pin level latency wrong");
  property p_hold; changeIrqSummaryFlag && !(acc && pwrite && paddr == pei_pkg::PEI_OFS_FLAGS)
    |=> changeIrqSummaryFlag; endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without write");
  property p_slverr; acc && paddr > 8'h14 |-> pslverr; endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access accepted");
  property p_upper; acc && !pwrite |-> prdata[31:6] == 26'h000_0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_rdflag; acc && !pwrite && paddr == pei_pkg::PEI_OFS_FLAGS
    |-> (|prdata[5:0]) == $past(changeIrqSummaryFlag); endproperty
  a_rdflag: assert property (p_rdflag) else $error("flags and summary disagree");
endmodule : pei_port_edge_asserts

bind pei_port_edge pei_port_edge_asserts pei_port_edge_asserts_inst (.sys_clk, .nrst, .paddr, .psel,
  .penable, .pwrite, .prdata, .pslverr, .portPinSchmitt, .portPinTtl, .portPinLevel, .changeIrqRequest,
  .wakeRequest, .changeIrqSummaryFlag);

// >>> pei_pin_model.sv
// Purpose: Pin-side model feeding both input buffers
// Assumes: Pins move just after a clock edge
// Notes: splitMask marks pins sitting between the two thresholds
`timescale 1ns/100ps
module pei_pin_model (
  input wire logic [5:0] wantLevel,
  input wire logic [5:0] splitMask,
  output logic [5:0] schmittOut,
  output logic [5:0] ttlOut
);
  assign schmittOut = wantLevel;
  assign ttlOut = wantLevel ^ splitMask;
endmodule : pei_pin_model

// >>> pei_port_edge_tb.sv
// Purpose: Self-checking bench for pei_port_edge
// Assumes: APB master tasks, pins from pei_pin_model
// Notes: Flags land three edges after a pin change
`timescale 1ns/100ps
module pei_port_edge_tb;
  logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic changeIrqRequest, wakeRequest, changeIrqSummaryFlag;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [5:0] want, split, portPinSchmitt, portPinTtl, portPinLevel;
  int failures, total_checks;
  logic lastErr;
  localparam logic [7:0] RIS = pei_pkg::PEI_OFS_RISE, FAL = pei_pkg::PEI_OFS_FALL;
  localparam logic [7:0] FLG = pei_pkg::PEI_OFS_FLAGS, CTL = pei_pkg::PEI_OFS_CTRL;
  pei_pin_model pei_pin_model_inst (.wantLevel(want), .splitMask(split), .schmittOut(portPinSchmitt),
    .ttlOut(portPinTtl));
  pei_port_edge pei_port_edge_inst (.sys_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .portPinSchmitt, .portPinTtl, .portPinLevel, .changeIrqRequest,
    .wakeRequest, .changeIrqSummaryFlag);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // One transfer, then an idle cycle so strobes never toggle twice in a step
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [7:0] exp);
    int n;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h00_0000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      failures++;
      tally_and_finish();
    end
    // Error flag stands only in the access phase, so catch it here
    lastErr = pslverr;
    if (!w) chk(prdata[7:0], exp);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  initial begin
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, want, split} = '0;
    pstrb = 4'hF;
    failures = 0;
    total_checks = 0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 7; i++) bus(8'(i * 4), 1'b0, 8'h00, 8'h00);
    // Last read of the loop hit an unmapped word
    chk({7'h00, lastErr}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      bus(8'(i * 4), 1'b1, 8'hFF, 8'h00);
      bus(8'(i * 4), 1'b0, 8'h00, 8'h3F);
      bus(8'(i * 4), 1'b1, 8'h00, 8'h00);
    end
    // Pins between thresholds read differently per buffer
    bus(pei_pkg::PEI_OFS_THRESH, 1'b1, 8'h3F, 8'h00);
    want <= 6'h15;
    split <= 6'h3F;
    repeat (3) @(posedge sys_clk);
    bus(pei_pkg::PEI_OFS_PINS, 1'b0, 8'h00, 8'h15);
    bus(pei_pkg::PEI_OFS_THRESH, 1'b1, 8'h0F, 8'h00);
    repeat (2) @(posedge sys_clk);
    bus(pei_pkg::PEI_OFS_PINS, 1'b0, 8'h00, 8'h25);
    want <= 6'h00;
    split <= 6'h00;
    repeat (3) @(posedge sys_clk);
    bus(FLG, 1'b0, 8'h00, 8'h00);
    bus(RIS, 1'b1, 8'h15, 8'h00);
    bus(FAL, 1'b1, 8'h0A, 8'h00);
    want <= 6'h3F;
    repeat (4) @(posedge sys_clk);
    bus(FLG, 1'b0, 8'h00, 8'h15);
    chk({5'h00, changeIrqRequest, wakeRequest, changeIrqSummaryFlag}, 8'h01);
    want <= 6'h00;
    repeat (4) @(posedge sys_clk);
    bus(FLG, 1'b0, 8'h00, 8'h1F);
    bus(CTL, 1'b1, 8'h01, 8'h00);
    chk({5'h00, changeIrqRequest, wakeRequest, changeIrqSummaryFlag}, 8'h07);
    bus(CTL, 1'b0, 8'h00, 8'h03);
    // Low byte strobe off: write must be dropped
    pstrb <= 4'hE;
    bus(CTL, 1'b1, 8'h00, 8'h00);
    pstrb <= 4'hF;
    bus(CTL, 1'b0, 8'h00, 8'h03);
    bus(FLG, 1'b1, 8'h1F & ~8'h15, 8'h00);
    bus(FLG, 1'b0, 8'h00, 8'h0A);
    bus(FLG, 1'b1, 8'h00, 8'h00);
    chk({5'h00, changeIrqRequest, wakeRequest, changeIrqSummaryFlag}, 8'h00);
    bus(RIS, 1'b1, 8'h3F, 8'h00);
    bus(FAL, 1'b1, 8'h3F, 8'h00);
    want <= 6'h04;
    repeat (4) @(posedge sys_clk);
    bus(FLG, 1'b0, 8'h00, 8'h04);
    // Falling edge lands on the edge of the clearing write
    want <= 6'h00;
    @(posedge sys_clk);
    bus(FLG, 1'b1, 8'h00, 8'h00);
    bus(FLG, 1'b0, 8'h00, 8'h04);
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 5; i++) bus(8'(i * 4), 1'b0, 8'h00, 8'h00);
    chk({7'h00, lastErr}, 8'h00);
    tally_and_finish();
  end
endmodule : pei_port_edge_tb
